// [design/amvf_top.sv]
/*
 * application mode, decimation, programmable filter and virtual converter
 * mapping for a dual converter with downconverters.
 * assumes samples and register strobes come from logic on core_clk_i.
 */
// How it works
// - mode from low four app bits
// - bit five selects real only output in downconverter modes
// - decimate by ratio in low bits
// - full bandwidth: a on 0, b on 1
// - up to four downconverter channels active
// - each stream owns one virtual converter
// - complex two streams, real one stream
// - at most eight converters, count per mode
// - i then q per channel, ascending
// - same count for digital or analog iq
// - 48-tap: each path own joined bank
// - 96-tap: all banks on i, q passes
// - cascaded: x then y per path
// - half complex: i passes, q mixed
// - full complex: cross coupled 24-tap banks
// - filter mode three bit encoding
// - coefficients signed, fifteen fraction bits
// - shadow coefficients applied on transfer bit
`timescale 1ns/1ns

module amvf_top
	import amvf_pkg::*;
(
	input  wire logic                     core_clk_i,
	input  wire logic                     reset_i,
	input  wire logic [ADDR_W-1:0]        reg_addr_i,
	input  wire logic [DATA_W-1:0]        reg_wdata_i,
	input  wire logic                     reg_wr_i,
	input  wire logic                     reg_rd_i,
	output logic [DATA_W-1:0]             reg_rdata_o,
	input  wire logic                     sample_en_i,
	input  wire logic [ADC_W-1:0]         adc_a_i,
	input  wire logic [ADC_W-1:0]         adc_b_i,
	input  wire amvf_iq_type [NUM_DDC-1:0] ddc_i,
	output logic [NUM_VC-1:0][SMP_W-1:0]  vc_data_o,
	output logic [NUM_VC-1:0]             vc_used_o,
	output logic [3:0]                    vc_count_o,
	output logic                          vc_valid_o
);

	amvf_top_state_type          st_r;
	amvf_top_state_type          st_nxt;
	amvf_iq_type                 din;
	logic [FIR_BANKS-1:0][SMP_W-1:0] bank_in;
	logic [FIR_BANKS-1:0][SMP_W-1:0] bank_out;
	logic [FIR_BANKS-1:0][SMP_W-1:0] bank_tail;
	logic signed [SMP_W+1:0]     sum_i;
	logic signed [SMP_W+1:0]     sum_q;
	logic [3:0]                  ratio_m1;

	// saturate a widened sum back to sample width
	function automatic logic [SMP_W-1:0] sat(input logic signed [SMP_W+1:0] v);
		logic signed [SMP_W+1:0] hi;
		logic signed [SMP_W+1:0] lo;
		hi = (SMP_W+2)'(2 ** (SMP_W - 1) - 1);
		lo = -hi - (SMP_W+2)'(1);
		if (v > hi)
			sat = hi[SMP_W-1:0];
		else if (v < lo)
			sat = lo[SMP_W-1:0];
		else
			sat = v[SMP_W-1:0];
	endfunction

	// sign-extend a bank output for summing
	function automatic logic signed [SMP_W+1:0] ext(input logic [SMP_W-1:0] v);
		ext = {{2{v[SMP_W-1]}}, v};
	endfunction

	// ========================================================
	// converter samples widened to the stream width
	always_comb
	begin
		din.i = {{(SMP_W-ADC_W){adc_a_i[ADC_W-1]}}, adc_a_i};
		din.q = {{(SMP_W-ADC_W){adc_b_i[ADC_W-1]}}, adc_b_i};
	end

	// ========================================================
	// filter banks, one per coefficient set
	for (genvar b = 0; b < FIR_BANKS; b++)
	begin : g_bank
		amvf_fir24 #(.TAPS(FIR_TAPS)) u_bank
		(
			.core_clk_i  (core_clk_i),
			.reset_i     (reset_i),
			.sample_en_i (sample_en_i),
			.din_i       (bank_in[b]),
			.coef_i      (st_r.active[b]),
			.dout_o      (bank_out[b]),
			.tail_o      (bank_tail[b])
		);
	end

	// ========================================================
	// bank input routing per filter mode
	always_comb
	begin
		bank_in[BANK_XI] = din.i;
		bank_in[BANK_YI] = bank_tail[BANK_XI];
		bank_in[BANK_XQ] = din.q;
		bank_in[BANK_YQ] = bank_tail[BANK_XQ];
		case (st_r.fir_i)
			FIR_CASC:  bank_in[BANK_YI] = bank_out[BANK_XI];
			FIR_FULLC: bank_in[BANK_YI] = din.i;
			FIR_R96:   bank_in[BANK_XQ] = bank_tail[BANK_YI];
			default:   bank_in[BANK_YI] = bank_tail[BANK_XI];
		endcase
		case (st_r.fir_q)
			FIR_CASC:  bank_in[BANK_YQ] = bank_out[BANK_XQ];
			FIR_FULLC: bank_in[BANK_YQ] = din.q;
			default:   bank_in[BANK_YQ] = bank_tail[BANK_XQ];
		endcase
	end

	// ========================================================
	// i path output select
	always_comb
	begin
		case (st_r.fir_i)
			FIR_R24:   sum_i = ext(bank_out[BANK_XI]);
			FIR_R48:   sum_i = ext(bank_out[BANK_XI])
				+ ext(bank_out[BANK_YI]);
			FIR_CASC:  sum_i = ext(bank_out[BANK_YI]);
			FIR_FULLC: sum_i = ext(bank_out[BANK_XI])
				+ ext(bank_out[BANK_YQ]);
			FIR_R96:   sum_i = ext(bank_out[BANK_XI])
				+ ext(bank_out[BANK_YI]) + ext(bank_out[BANK_XQ])
				+ ext(bank_out[BANK_YQ]);
			default:   sum_i = ext(din.i);
		endcase
	end

	// ========================================================
	// q path output select, cross modes follow the i setting
	always_comb
	begin
		case (st_r.fir_q)
			FIR_R24:  sum_q = ext(bank_out[BANK_XQ]);
			FIR_R48:  sum_q = ext(bank_out[BANK_XQ])
				+ ext(bank_out[BANK_YQ]);
			FIR_CASC: sum_q = ext(bank_out[BANK_YQ]);
			default:  sum_q = ext(din.q);
		endcase
		// keyed on the i setting alone, whatever fir_q holds
		if (st_r.fir_i == FIR_FULLC)
			sum_q = ext(bank_out[BANK_XQ]) + ext(bank_out[BANK_YI]);
		else if (st_r.fir_i == FIR_HALFC)
			sum_q = ext(bank_out[BANK_XQ]) + ext(bank_out[BANK_YQ])
				+ ext(bank_out[BANK_XI]) + ext(bank_out[BANK_YI]);
		else if (st_r.fir_i == FIR_R96)
			sum_q = ext(din.q);
	end

	// ========================================================
	// decimation ratio, zero is taken as one
	assign ratio_m1 = (st_r.decim == 4'h0) ? 4'h0 : st_r.decim - 4'h1;

	// ========================================================
	// next state: registers, coefficient store, datapath
	always_comb
	begin
		st_nxt = st_r;
		st_nxt.rdata = '0;
		st_nxt.dec_stb = 1'b0;

		// register writes
		if (reg_wr_i)
		begin
			case (reg_addr_i)
				REG_APP_MODE:
				begin
					st_nxt.app_mode = reg_wdata_i[MODE_LSB+:4];
					st_nxt.q_ignore = reg_wdata_i[QIGN_BIT];
				end
				REG_DECIM: st_nxt.decim = reg_wdata_i[DECIM_LSB+:4];
				REG_FIR_I: st_nxt.fir_i = reg_wdata_i[2:0];
				REG_FIR_Q: st_nxt.fir_q = reg_wdata_i[2:0];
				REG_COEF_PTR:
				begin
					st_nxt.ptr_tap = reg_wdata_i[4:0];
					st_nxt.ptr_bank = reg_wdata_i[PTR_BANK+:2];
				end
				REG_COEF_DAT:
				begin
					if (st_r.ptr_tap < 5'(FIR_TAPS))
						st_nxt.shadow[st_r.ptr_bank][st_r.ptr_tap] =
							reg_wdata_i;
					st_nxt.ptr_tap = st_r.ptr_tap + 5'h1;
				end
				REG_XFER:
				begin
					if (reg_wdata_i[XFER_BIT])
						st_nxt.active = st_r.shadow;
				end
				default: st_nxt.ptr_tap = st_r.ptr_tap;
			endcase
		end

		// register reads, data in the following cycle
		if (reg_rd_i)
		begin
			case (reg_addr_i)
				REG_APP_MODE: st_nxt.rdata = DATA_W'({st_r.q_ignore,
					1'b0, st_r.app_mode});
				REG_DECIM:    st_nxt.rdata = DATA_W'(st_r.decim);
				REG_FIR_I:    st_nxt.rdata = DATA_W'(st_r.fir_i);
				REG_FIR_Q:    st_nxt.rdata = DATA_W'(st_r.fir_q);
				REG_COEF_PTR: st_nxt.rdata = DATA_W'({st_r.ptr_bank,
					st_r.ptr_tap});
				REG_STATUS:   st_nxt.rdata = {4'h0, vc_count_o,
					vc_used_o};
				default:      st_nxt.rdata = '0;
			endcase
		end

		// one filtered sample per converter sample
		if (sample_en_i)
		begin
			// bypass paths share the one cycle latency
			st_nxt.fir_out.i = sat(sum_i);
			st_nxt.fir_out.q = sat(sum_q);
			st_nxt.ddc = ddc_i;
			if (st_r.dec_cnt >= ratio_m1)
			begin
				st_nxt.dec_cnt = 4'h0;
				st_nxt.dec_stb = 1'b1;
			end
			else
				st_nxt.dec_cnt = st_r.dec_cnt + 4'h1;
		end
	end

	// ========================================================
	// state register
	always_ff @(posedge core_clk_i)
	begin
		if (reset_i)
		begin
			st_r <= '0;
			st_r.app_mode <= APP_MODE_RST;
			st_r.q_ignore <= QIGN_RST;
			st_r.decim <= DECIM_RST;
		end
		else
			st_r <= st_nxt;
	end

	assign reg_rdata_o = st_r.rdata;

	// ========================================================
	// virtual converter mapping
	// one slot per stream
	// same slot pairing for both sources
	amvf_vc_map u_map
	(
		.core_clk_i (core_clk_i),
		.reset_i    (reset_i),
		.stb_i      (st_r.dec_stb),
		.app_mode_i (st_r.app_mode),
		.q_ignore_i (st_r.q_ignore),
		.full_bw_i  (st_r.fir_out),
		.ddc_i      (st_r.ddc),
		.vc_data_o  (vc_data_o),
		.vc_used_o  (vc_used_o),
		.vc_count_o (vc_count_o),
		.vc_valid_o (vc_valid_o)
	);

endmodule

// [design/amvf_pkg.sv]
/*
 * shared constants and types for the application mode, virtual converter
 * mapping and programmable filter block.
 * assumes one sample clock and a plain register port of 16 data bits.
 */
package amvf_pkg;

	// ========================================================
	// sizes
	localparam int SMP_W     = 16;
	localparam int ADC_W     = 14;
	localparam int COEF_W    = 16;
	localparam int COEF_FRAC = 15;
	localparam int FIR_TAPS  = 24;
	localparam int FIR_BANKS = 4;
	localparam int NUM_VC    = 8;
	localparam int NUM_DDC   = 4;
	localparam int ADDR_W    = 12;
	localparam int DATA_W    = 16;

	// ========================================================
	// register offsets
	localparam logic [ADDR_W-1:0] REG_XFER     = 12'h00F;
	localparam logic [ADDR_W-1:0] REG_APP_MODE = 12'h200;
	localparam logic [ADDR_W-1:0] REG_DECIM    = 12'h201;
	localparam logic [ADDR_W-1:0] REG_FIR_I    = 12'h300;
	localparam logic [ADDR_W-1:0] REG_FIR_Q    = 12'h301;
	localparam logic [ADDR_W-1:0] REG_COEF_PTR = 12'h302;
	localparam logic [ADDR_W-1:0] REG_COEF_DAT = 12'h303;
	localparam logic [ADDR_W-1:0] REG_STATUS   = 12'h304;

	// ========================================================
	// field positions and reset values
	localparam int MODE_LSB  = 0;
	localparam int QIGN_BIT  = 5;
	localparam int DECIM_LSB = 0;
	localparam int XFER_BIT  = 0;
	localparam int PTR_BANK  = 5;
	localparam logic [3:0] APP_MODE_RST = 4'h0;
	localparam logic       QIGN_RST     = 1'b0;
	localparam logic [3:0] DECIM_RST    = 4'h1;

	// ========================================================
	// coefficient bank indices
	localparam int BANK_XI = 0;
	localparam int BANK_YI = 1;
	localparam int BANK_XQ = 2;
	localparam int BANK_YQ = 3;

	typedef enum logic [3:0]
	{
		APP_FULL_BW = 4'h0,
		APP_ONE_DDC = 4'h1,
		APP_TWO_DDC = 4'h2,
		APP_FOUR_DDC = 4'h3
	} amvf_app_type;

	typedef enum logic [2:0]
	{
		FIR_BYPASS = 3'h0,
		FIR_R24    = 3'h1,
		FIR_R48    = 3'h2,
		FIR_CASC   = 3'h4,
		FIR_FULLC  = 3'h5,
		FIR_HALFC  = 3'h6,
		FIR_R96    = 3'h7
	} amvf_fir_type;

	typedef struct packed
	{
		logic signed [SMP_W-1:0] i;
		logic signed [SMP_W-1:0] q;
	} amvf_iq_type;

	typedef logic [FIR_BANKS-1:0][FIR_TAPS-1:0][COEF_W-1:0] amvf_coef_type;

	typedef struct packed
	{
		logic [3:0]                          app_mode;
		logic                                q_ignore;
		logic [3:0]                          decim;
		logic [2:0]                          fir_i;
		logic [2:0]                          fir_q;
		logic [1:0]                          ptr_bank;
		logic [4:0]                          ptr_tap;
		amvf_coef_type                       shadow;
		amvf_coef_type                       active;
		logic [3:0]                          dec_cnt;
		logic                                dec_stb;
		logic [DATA_W-1:0]                   rdata;
		amvf_iq_type                         fir_out;
		amvf_iq_type [NUM_DDC-1:0]           ddc;
	} amvf_top_state_type;

	typedef struct packed
	{
		logic [NUM_VC-1:0][SMP_W-1:0] data;
		logic [NUM_VC-1:0]            used;
		logic [3:0]                   count;
		logic                         valid;
	} amvf_vc_state_type;

endpackage

// [design/amvf_fir24.sv]
/*
 * one 24-tap real filter bank: delay line, Q1.15 multiply and sum.
 * assumes the caller registers the result; tail_o feeds a chained bank.
 */
`timescale 1ns/1ns

module amvf_fir24
	import amvf_pkg::*;
#(
	parameter int TAPS = FIR_TAPS
)
(
	input  wire logic                      core_clk_i,
	input  wire logic                      reset_i,
	input  wire logic                      sample_en_i,
	input  wire logic signed [SMP_W-1:0]   din_i,
	input  wire logic [TAPS-1:0][COEF_W-1:0] coef_i,
	output logic signed [SMP_W-1:0]        dout_o,
	output logic signed [SMP_W-1:0]        tail_o
);

	generate
		if (TAPS < 3)
		begin : g_chk
			$error("amvf_fir24 needs at least three taps");
		end
	endgenerate

	logic [TAPS-2:0][SMP_W-1:0] line_r;
	logic [TAPS-2:0][SMP_W-1:0] line_nxt;
	logic signed [39:0]         acc;

	// ========================================================
	// delay line, moves once per sample
	always_comb
	begin
		line_nxt = line_r;
		if (sample_en_i)
			line_nxt = {line_r[TAPS-3:0], din_i};
	end

	always_ff @(posedge core_clk_i)
	begin
		if (reset_i)
			line_r <= '0;
		else
			line_r <= line_nxt;
	end

	// ========================================================
	// convolution, coefficients signed with fifteen fraction bits
	always_comb
	begin
		acc = 40'(signed'(din_i) * signed'(coef_i[0]));
		for (int k = 1; k < TAPS; k++)
			acc = acc + 40'(signed'(line_r[k-1]) * signed'(coef_i[k]));
		dout_o = acc[COEF_FRAC+SMP_W-1:COEF_FRAC];
		tail_o = line_r[TAPS-2];
	end

endmodule

// [design/amvf_vc_map.sv]
/*
 * maps full bandwidth or downconverter streams onto eight virtual
 * converter slots. assumes stb_i marks one decimated output sample.
 */
`timescale 1ns/1ns

module amvf_vc_map
	import amvf_pkg::*;
(
	input  wire logic                     core_clk_i,
	input  wire logic                     reset_i,
	input  wire logic                     stb_i,
	input  wire logic [3:0]               app_mode_i,
	input  wire logic                     q_ignore_i,
	input  wire amvf_iq_type              full_bw_i,
	input  wire amvf_iq_type [NUM_DDC-1:0] ddc_i,
	output logic [NUM_VC-1:0][SMP_W-1:0]  vc_data_o,
	output logic [NUM_VC-1:0]             vc_used_o,
	output logic [3:0]                    vc_count_o,
	output logic                          vc_valid_o
);

	amvf_vc_state_type            st_r;
	amvf_vc_state_type            st_nxt;
	logic [NUM_VC-1:0][SMP_W-1:0] slot_data;
	logic [NUM_VC-1:0]            slot_used;
	logic [3:0]                   nch;
	logic [3:0]                   cnt;

	// ========================================================
	// active downconverter channels and converter count
	always_comb
	begin
		nch = 4'h0;
		cnt = 4'h0;
		case (app_mode_i)
			APP_FULL_BW:
			begin
				cnt = 4'h2;
			end
			APP_ONE_DDC:  nch = 4'h1;
			APP_TWO_DDC:  nch = 4'h2;
			APP_FOUR_DDC: nch = 4'h4;
			default:      nch = 4'h0;
		endcase
		if (app_mode_i != APP_FULL_BW)
			cnt = q_ignore_i ? nch : 4'(nch << 1);
	end

	// ========================================================
	// per slot source select, unused slots forced to zero
	for (genvar k = 0; k < NUM_VC; k++)
	begin : g_slot
		always_comb
		begin
			slot_used[k] = 1'b0;
			slot_data[k] = '0;
			if (app_mode_i == APP_FULL_BW)
			begin
				slot_used[k] = (k < 2);
				slot_data[k] = (k == 0) ? full_bw_i.i : full_bw_i.q;
			end
			else if (q_ignore_i)
			begin
				slot_used[k] = (k < 32'(nch));
				slot_data[k] = ddc_i[k % NUM_DDC].i;
			end
			else
			begin
				slot_used[k] = ((k / 2) < 32'(nch));
				slot_data[k] = (k % 2 == 1) ? ddc_i[k / 2].q
					: ddc_i[k / 2].i;
			end
			if (!slot_used[k])
				slot_data[k] = '0;
		end
	end

	// ========================================================
	// output register, slot data loads on each decimated sample, used and count every cycle
	always_comb
	begin
		st_nxt = st_r;
		st_nxt.valid = stb_i;
		st_nxt.used = slot_used;
		st_nxt.count = cnt;
		if (stb_i)
			st_nxt.data = slot_data;
	end

	always_ff @(posedge core_clk_i)
	begin
		if (reset_i)
			st_r <= '0;
		else
			st_r <= st_nxt;
	end

	assign vc_data_o  = st_r.data;
	assign vc_used_o  = st_r.used;
	assign vc_count_o = st_r.count;
	assign vc_valid_o = st_r.valid;

endmodule

// [sim/amvf_top_props.sv]
/*
 * port checker for amvf_top: readback, slot use and output pacing.
 * assumes it is bound to amvf_top and sees only its ports.
 */
`timescale 1ns/1ns

module amvf_top_props
	import amvf_pkg::*;
(
	input  wire logic                         core_clk_i,
	input  wire logic                         reset_i,
	input  wire logic [ADDR_W-1:0]            reg_addr_i,
	input  wire logic [DATA_W-1:0]            reg_wdata_i,
	input  wire logic                         reg_wr_i,
	input  wire logic                         reg_rd_i,
	input  wire logic [DATA_W-1:0]            reg_rdata_o,
	input  wire logic                         sample_en_i,
	input  wire logic [NUM_VC-1:0][SMP_W-1:0] vc_data_o,
	input  wire logic [NUM_VC-1:0]            vc_used_o,
	input  wire logic [3:0]                   vc_count_o,
	input  wire logic                         vc_valid_o
);
	logic [SMP_W-1:0] stray;
	logic [8:0]       mask;
	logic             app_wr;
	logic [3:0]       wmode;
	logic             wq;

	function automatic logic [3:0] need(input logic [3:0] m, input logic q);
		case (m)
			4'h0: need = 4'h2;
			4'h1: need = q ? 4'h1 : 4'h2;
			4'h2: need = q ? 4'h2 : 4'h4;
			4'h3: need = q ? 4'h4 : 4'h8;
			default: need = 4'h0;
		endcase
	endfunction

	// ========================================
	// helpers: data left in unused slots
	always_comb
	begin
		stray = '0;
		for (int k = 0; k < NUM_VC; k++)
		begin
			if (!vc_used_o[k])
				stray = stray | vc_data_o[k];
		end
		mask = (9'h001 << vc_count_o) - 9'h001;
		app_wr = reg_wr_i && (reg_addr_i == REG_APP_MODE);
		wmode = reg_wdata_i[3:0];
		wq = reg_wdata_i[5];
	end

	default clocking cb @(posedge core_clk_i);
	endclocking
	default disable iff (reset_i);

	// ========================================
	// assertions
	AST_MODE_COUNT:
	assert property (app_wr && !(wmode == 4'h0 && wq) |-> ##2
		vc_count_o == need($past(wmode, 2), $past(wq, 2)))
	else $error("count does not follow mode write");
	AST_REAL_COUNT:
	assert property (app_wr && wq |-> ##2 vc_count_o <= 4'h4)
	else $error("real output uses too many converters");
	AST_COMPLEX_PAIRS:
	assert property (app_wr && !wq && wmode inside {4'h1, 4'h2, 4'h3}
		|-> ##2 !vc_count_o[0])
	else $error("complex output count is odd");
	AST_XFER_READ:
	assert property (reg_rd_i && reg_addr_i == REG_XFER |=> reg_rdata_o == '0)
	else $error("transfer register reads nonzero");
	AST_COUNT_LEGAL:
	assert property (vc_count_o inside {4'h0, 4'h1, 4'h2, 4'h4, 4'h8})
	else $error("illegal converter count");
	AST_USED_ASCEND:
	assert property (vc_used_o == mask[7:0])
	else $error("used slots not packed from slot zero");
	AST_UNUSED_EMPTY:
	assert property (vc_valid_o |-> stray == '0)
	else $error("unused slot carries data");
	AST_VALID_PACE:
	assert property (vc_valid_o |-> $past(sample_en_i, 2))
	else $error("output without a sample two edges back");
	AST_DATA_HOLD:
	assert property (!vc_valid_o |-> $stable(vc_data_o))
	else $error("slot data moved without valid");

	// main scenarios reached
	cover property (vc_count_o == 4'h8);
	cover property (vc_valid_o && vc_count_o == 4'h1);
	cover property (app_wr && wq);
endmodule

bind amvf_top amvf_top_props u_props
(
	.core_clk_i  (core_clk_i),
	.reset_i     (reset_i),
	.reg_addr_i  (reg_addr_i),
	.reg_wdata_i (reg_wdata_i),
	.reg_wr_i    (reg_wr_i),
	.reg_rd_i    (reg_rd_i),
	.reg_rdata_o (reg_rdata_o),
	.sample_en_i (sample_en_i),
	.vc_data_o   (vc_data_o),
	.vc_used_o   (vc_used_o),
	.vc_count_o  (vc_count_o),
	.vc_valid_o  (vc_valid_o)
);

// [sim/amvf_link_rx.sv]
/*
 * transport receiver model: keeps the last frame of slots and a count.
 * assumes slot data are taken only in a cycle with valid high.
 */
`timescale 1ns/1ns

module amvf_link_rx
	import amvf_pkg::*;
(
	input  wire logic                         core_clk_i,
	input  wire logic                         reset_i,
	input  wire logic                         vc_valid_i,
	input  wire logic [NUM_VC-1:0][SMP_W-1:0] vc_data_i,
	output logic [NUM_VC-1:0][SMP_W-1:0]      frame_o,
	output logic [15:0]                       frames_o
);
	// ========================================
	// each slot its own converter
	always_ff @(posedge core_clk_i)
	begin
		if (reset_i)
		begin
			frame_o <= '0;
			frames_o <= 16'h0000;
		end
		else if (vc_valid_i)
		begin
			frame_o <= vc_data_i;
			frames_o <= frames_o + 16'h0001;
		end
	end
endmodule

// [sim/app_mode_vc_map_fir_test.sv]
/*
 * bench for amvf_top: modes, slot mapping, decimation and filter modes.
 * assumes the receiver model and the bound port checker.
 */
`timescale 1ns/1ns

module app_mode_vc_map_fir_test
	import amvf_pkg::*;
;
	logic                         core_clk = 1'b0;
	logic                         reset = 1'b1;
	logic [ADDR_W-1:0]            addr = '0;
	logic [DATA_W-1:0]            wdata = '0;
	logic                         wr = 1'b0;
	logic                         rd = 1'b0;
	logic                         sen = 1'b0;
	logic [ADC_W-1:0]             adc_a = '0;
	logic [ADC_W-1:0]             adc_b = '0;
	amvf_iq_type [NUM_DDC-1:0]    ddc = '0;
	logic [DATA_W-1:0]            rdata;
	logic [NUM_VC-1:0][SMP_W-1:0] frame;
	logic [NUM_VC-1:0]            used;
	logic [3:0]                   count;
	logic                         valid;
	logic [15:0]                  frames;
	logic [15:0]                  f0;
	logic [DATA_W-1:0]            got;
	logic [3:0]                   e;
	logic [7:0]                   um;
	logic [NUM_VC-1:0][SMP_W-1:0] vcd;
	logic signed [SMP_W-1:0]      sa, sb, hs, hb, ei, eq;
	logic [2:0]                   fm [7] = '{3'h0, 3'h1, 3'h2, 3'h4, 3'h5,
		3'h6, 3'h7};
	int                           seed = 61;
	int                           n_mismatch = 0;
	int                           tests_run = 0;
	int                           r;

	always #5 core_clk = ~core_clk;

	amvf_top u_dut
	(
		.core_clk_i  (core_clk),
		.reset_i     (reset),
		.reg_addr_i  (addr),
		.reg_wdata_i (wdata),
		.reg_wr_i    (wr),
		.reg_rd_i    (rd),
		.reg_rdata_o (rdata),
		.sample_en_i (sen),
		.adc_a_i     (adc_a),
		.adc_b_i     (adc_b),
		.ddc_i       (ddc),
		.vc_data_o   (vcd),
		.vc_used_o   (used),
		.vc_count_o  (count),
		.vc_valid_o  (valid)
	);

	amvf_link_rx u_rx
	(
		.core_clk_i (core_clk),
		.reset_i    (reset),
		.vc_valid_i (valid),
		.vc_data_i  (vcd),
		.frame_o    (frame),
		.frames_o   (frames)
	);

	// ========================================
	// tasks and expectations
	task automatic check(input string what, input logic [15:0] seen,
		input logic [15:0] expd);
		tests_run++;
		if (seen !== expd)
		begin
			n_mismatch++;
			$display("ERROR %s expected %h seen %h", what, expd, seen);
		end
	endtask

	task automatic step(input int n);
		repeat (n) @(posedge core_clk);
	endtask

	task automatic wr_reg(input logic [ADDR_W-1:0] a, input logic [15:0] d);
		@(posedge core_clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge core_clk);
		wr <= 1'b0;
	endtask

	task automatic rd_reg(input logic [ADDR_W-1:0] a, output logic [15:0] d);
		@(posedge core_clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge core_clk);
		rd <= 1'b0;
		#1 d = rdata;
	endtask

	// one sample, fresh downconverter values beside it
	task automatic pulse();
		@(posedge core_clk);
		for (int k = 0; k < NUM_DDC; k++)
			ddc[k] <= amvf_iq_type'($random(seed));
		sen <= 1'b1;
		@(posedge core_clk);
		sen <= 1'b0;
	endtask

	function automatic logic [3:0] cnt_exp(input int m, input int q);
		case (m)
			0: cnt_exp = 4'h2;
			1: cnt_exp = q ? 4'h1 : 4'h2;
			2: cnt_exp = q ? 4'h2 : 4'h4;
			3: cnt_exp = q ? 4'h4 : 4'h8;
			default: cnt_exp = 4'h0;
		endcase
	endfunction

	function automatic logic [15:0] slot_exp(input int m, input int q,
		input int k);
		int n;
		n = (m == 3) ? 4 : ((m == 4) ? 0 : m);
		if (q)
			slot_exp = (k < n) ? ddc[k].i : '0;
		else if (k >= 2 * n)
			slot_exp = '0;
		else
			slot_exp = k[0] ? ddc[k / 2].q : ddc[k / 2].i;
	endfunction

	// tap zero at minus one half, truncated like a Q1.15 product
	function automatic logic signed [15:0] hf(input logic signed [15:0] x);
		hf = 16'((32'(x) * -32'sd16384) >>> 15);
	endfunction

	task automatic results();
		$display("checks %0d mismatches %0d", tests_run, n_mismatch);
		if (n_mismatch == 0 && tests_run > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	// ========================================
	// watchdog
	initial
	begin
		#400_000;
		n_mismatch++;
		results();
	end

	// ========================================
	// main sequence
	initial
	begin
		step(6);
		reset <= 1'b0;
		rd_reg(REG_APP_MODE, got);
		check("app reset", got, 16'h0000);
		rd_reg(REG_DECIM, got);
		check("decim reset", got, 16'h0001);
		rd_reg(REG_FIR_I, got);
		check("fir reset", got, 16'h0000);
		rd_reg(12'h0FF, got);
		check("unmapped read", got, 16'h0000);
		rd_reg(REG_XFER, got);
		check("xfer read", got, 16'h0000);
		for (int m = 0; m < 5; m++)
			for (int q = 0; q < 2; q++)
			begin
				if (m == 0 && q == 1)
					continue;
				wr_reg(REG_APP_MODE, 16'(q * 32 + m));
				step(3);
				e = cnt_exp(m, q);
				um = 8'((16'h0001 << e) - 16'h0001);
				rd_reg(REG_APP_MODE, got);
				check("app back", got, 16'(q * 32 + m));
				check("count", {12'h000, count}, {12'h000, e});
				check("used", {8'h00, used}, {8'h00, um});
				rd_reg(REG_STATUS, got);
				check("status", got, {4'h0, e, um});
				if (m == 0)
					continue;
				f0 = frames;
				pulse();
				step(4);
				check("frame", frames - f0, 16'h0001);
				for (int k = 0; k < NUM_VC; k++)
					check("slot", frame[k], slot_exp(m, q, k));
			end
		wr_reg(REG_APP_MODE, 16'h0001);
		for (int j = 0; j < 4; j++)
		begin
			r = (j == 0) ? 15 : 2 + (($random(seed) & 32'h7FFF_FFFF) % 13);
			wr_reg(REG_DECIM, 16'(r));
			f0 = frames;
			for (int i = 0; i < 20 && frames == f0; i++)
			begin
				pulse();
				step(3);
			end
			f0 = frames;
			repeat (2 * r) pulse();
			step(4);
			check("ratio frames", frames - f0, 16'h0002);
		end
		wr_reg(REG_DECIM, 16'h0001);
		wr_reg(REG_APP_MODE, 16'h0000);
		@(posedge core_clk);
		adc_a <= 14'($random(seed));
		adc_b <= 14'($random(seed));
		sen <= 1'b1;
		// minus one half on tap zero of every bank
		for (int b = 0; b < FIR_BANKS; b++)
		begin
			wr_reg(REG_COEF_PTR, 16'(b * 32));
			wr_reg(REG_COEF_DAT, 16'hC000);
		end
		rd_reg(REG_COEF_PTR, got);
		check("ptr back", got, 16'h0061);
		wr_reg(REG_FIR_I, 16'h0001);
		wr_reg(REG_FIR_Q, 16'h0001);
		step(8);
		check("before xfer", frame[0], 16'h0000);
		wr_reg(REG_XFER, 16'h0001);
		sa = {{2{adc_a[13]}}, adc_a};
		sb = {{2{adc_b[13]}}, adc_b};
		hs = hf(sa);
		hb = hf(sb);
		foreach (fm[i])
		begin
			wr_reg(REG_FIR_I, {13'h0000, fm[i]});
			wr_reg(REG_FIR_Q, {13'h0000, fm[i]});
			// long enough for the chained delay lines to fill
			step(40);
			case (fm[i])
				3'h0: {ei, eq} = {sa, sb};
				3'h1: {ei, eq} = {hs, hb};
				3'h2: {ei, eq} = {16'(hs + hs), 16'(hb + hb)};
				3'h4: {ei, eq} = {hf(hs), hf(hb)};
				3'h5: {ei, eq} = {16'(hs + hb), 16'(hb + hs)};
				3'h6: {ei, eq} = {sa, 16'(hs + hs + hb + hb)};
				default: {ei, eq} = {16'(4 * hs), sb};
			endcase
			check("i path", frame[0], ei);
			check("q path", frame[1], eq);
		end
		@(posedge core_clk);
		sen <= 1'b0;
		results();
	end
endmodule
